//--- cpu_register_and_flags.sv
// dedicated cpu registers, condition code logic and register bank addressing
`timescale 1ns/1ps

// Function
// - one 64 Kbyte space holds I/O, data and program areas
// - I/O sits lowest, data directly above, program at the top
// - program counter is 16 bits, locating the fetched instruction
// - accumulator is 16 bits; byte operations touch only its low byte
// - 16-bit temporary accumulator is the second arithmetic operand
// - 16-bit index register supplies the indexed address offset
// - 16-bit extra pointer holds any memory address
// - 16-bit stack pointer marks the current stack location
// - status word: bank pointer high byte, condition codes low byte
// - half carry reflects carry or borrow between bit 3 and bit 4
// - interrupt enable: 1 permits, 0 blocks, cleared by reset
// - two-bit level mask admits only higher priority; level 3 blocks all
// - negative flag copies the result's top bit
// - zero flag set for a zero result, cleared otherwise
// - overflow flag reports two's-complement overflow
// - carry takes carry or borrow out of bit 7 (bit 15 for 16-bit operations), or shifted-out bit
// - byte-wide general registers in memory, eight per bank, 32 banks
// - 16 banks internal; upper 16 need external RAM at 0180H-01FFH
// - bank pointer selects the bank used by register accesses
module cpu_register_and_flags #(
	parameter logic [15:0] PROG_START = cpu_regs_pkg::PROG_FIRST,
	parameter int          INT_BANKS  = cpu_regs_pkg::BANKS_INT
) (
	// clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// execution datapath
	input  wire cpu_regs_pkg::dp_write_t dp_write,
	input  wire cpu_regs_pkg::alu_req_t  alu_req,
	input  wire logic                    pc_step,
	// interrupt request level check
	input  wire logic                    irq_pending,
	input  wire logic [1:0]              irq_level,
	output logic                         irq_accept,
	// address decode and register bank
	input  wire logic [15:0]             mem_addr,
	output cpu_regs_pkg::region_t        mem_region,
	input  wire logic [2:0]              gpr_index,
	output logic      [15:0]             gpr_addr,
	output logic                         gpr_external,
	// register contents
	output cpu_regs_pkg::cpu_regs_t      regs
);

	logic [15:0] pc_q;
	logic [15:0] acc_q;
	logic [15:0] acc_d;
	logic [15:0] tmp_q;
	logic [15:0] ix_q;
	logic [15:0] ep_q;
	logic [15:0] sp_q;
	logic [7:0]  rp_q;
	logic [7:0]  ccr_q;
	logic [7:0]  ccr_d;
	logic        apb_wr;
	logic        apb_rd;
	logic        mapped;
	logic [31:0] rdata_d;
	logic [4:0]  bank;

	// merge a 16-bit word with byte strobes on the low two lanes
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
			input logic [3:0] st);
		merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction : merge16

	// true when the apb write targets the given offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// apb handshake: zero wait states, error on unmapped offsets
	assign pready  = 1'b1;
	assign apb_wr  = psel && penable && pwrite;
	assign apb_rd  = psel && penable && !pwrite;
	assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= cpu_regs_pkg::OFS_STAT);
	assign pslverr = psel && penable && (!mapped || (pwrite && hit(paddr, cpu_regs_pkg::OFS_STAT)));

	// program counter: datapath load, then step, then software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_q <= cpu_regs_pkg::PC_RST;
		end else if (dp_write.valid && dp_write.sel == cpu_regs_pkg::SEL_PC) begin
			pc_q <= dp_write.data;
		end else if (pc_step) begin
			pc_q <= pc_q + 16'h0001;
		end else if (apb_wr && hit(paddr, cpu_regs_pkg::OFS_PC)) begin
			pc_q <= merge16(pc_q, pwdata, pstrb);
		end
	end

	// arithmetic result and flags from accumulator and temporary accumulator
	always_comb begin
		logic [8:0]  r9;
		logic [16:0] r17;
		logic [4:0]  nib;
		r9    = 9'h000;
		r17   = 17'h00000;
		nib   = 5'h00;
		acc_d = acc_q;
		ccr_d = ccr_q;
		unique case (alu_req.op)
			cpu_regs_pkg::OP_ADD8: begin
				r9  = {1'b0, acc_q[7:0]} + {1'b0, tmp_q[7:0]};
				nib = {1'b0, acc_q[3:0]} + {1'b0, tmp_q[3:0]};
				acc_d = {acc_q[15:8], r9[7:0]};
				ccr_d[cpu_regs_pkg::CCR_H] = nib[4];
				ccr_d[cpu_regs_pkg::CCR_C] = r9[8];
				ccr_d[cpu_regs_pkg::CCR_V] = (acc_q[7] == tmp_q[7]) && (r9[7] != acc_q[7]);
				ccr_d[cpu_regs_pkg::CCR_N] = r9[7];
				ccr_d[cpu_regs_pkg::CCR_Z] = (r9[7:0] == 8'h00);
			end
			cpu_regs_pkg::OP_SUB8: begin
				r9  = {1'b0, acc_q[7:0]} - {1'b0, tmp_q[7:0]};
				nib = {1'b0, acc_q[3:0]} - {1'b0, tmp_q[3:0]};
				acc_d = {acc_q[15:8], r9[7:0]};
				ccr_d[cpu_regs_pkg::CCR_H] = nib[4];
				ccr_d[cpu_regs_pkg::CCR_C] = r9[8];
				ccr_d[cpu_regs_pkg::CCR_V] = (acc_q[7] != tmp_q[7]) && (r9[7] != acc_q[7]);
				ccr_d[cpu_regs_pkg::CCR_N] = r9[7];
				ccr_d[cpu_regs_pkg::CCR_Z] = (r9[7:0] == 8'h00);
			end
			cpu_regs_pkg::OP_ADD16: begin
				r17 = {1'b0, acc_q} + {1'b0, tmp_q};
				nib = {1'b0, acc_q[3:0]} + {1'b0, tmp_q[3:0]};
				acc_d = r17[15:0];
				ccr_d[cpu_regs_pkg::CCR_H] = nib[4];
				ccr_d[cpu_regs_pkg::CCR_C] = r17[16];
				ccr_d[cpu_regs_pkg::CCR_V] = (acc_q[15] == tmp_q[15]) && (r17[15] != acc_q[15]);
				ccr_d[cpu_regs_pkg::CCR_N] = r17[15];
				ccr_d[cpu_regs_pkg::CCR_Z] = (r17[15:0] == 16'h0000);
			end
			cpu_regs_pkg::OP_SUB16: begin
				r17 = {1'b0, acc_q} - {1'b0, tmp_q};
				nib = {1'b0, acc_q[3:0]} - {1'b0, tmp_q[3:0]};
				acc_d = r17[15:0];
				ccr_d[cpu_regs_pkg::CCR_H] = nib[4];
				ccr_d[cpu_regs_pkg::CCR_C] = r17[16];
				ccr_d[cpu_regs_pkg::CCR_V] = (acc_q[15] != tmp_q[15]) && (r17[15] != acc_q[15]);
				ccr_d[cpu_regs_pkg::CCR_N] = r17[15];
				ccr_d[cpu_regs_pkg::CCR_Z] = (r17[15:0] == 16'h0000);
			end
			cpu_regs_pkg::OP_SHL8: begin
				acc_d = {acc_q[15:8], acc_q[6:0], 1'b0};
				ccr_d[cpu_regs_pkg::CCR_C] = acc_q[7];
				ccr_d[cpu_regs_pkg::CCR_N] = acc_q[6];
				ccr_d[cpu_regs_pkg::CCR_Z] = (acc_q[6:0] == 7'h00);
			end
			cpu_regs_pkg::OP_SHR8: begin
				acc_d = {acc_q[15:8], 1'b0, acc_q[7:1]};
				ccr_d[cpu_regs_pkg::CCR_C] = acc_q[0];
				ccr_d[cpu_regs_pkg::CCR_N] = 1'b0;
				ccr_d[cpu_regs_pkg::CCR_Z] = (acc_q[7:1] == 7'h00);
			end
			default: begin
				acc_d = acc_q;
				ccr_d = ccr_q;
			end
		endcase
	end

	// accumulator: arithmetic result, datapath load, software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= cpu_regs_pkg::REG_RST;
		end else if (alu_req.valid) begin
			acc_q <= acc_d;
		end else if (dp_write.valid && dp_write.sel == cpu_regs_pkg::SEL_ACC) begin
			acc_q <= dp_write.data;
		end else if (apb_wr && hit(paddr, cpu_regs_pkg::OFS_ACC)) begin
			acc_q <= merge16(acc_q, pwdata, pstrb);
		end
	end

	// temporary accumulator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmp_q <= cpu_regs_pkg::REG_RST;
		end else if (dp_write.valid && dp_write.sel == cpu_regs_pkg::SEL_TMP) begin
			tmp_q <= dp_write.data;
		end else if (apb_wr && hit(paddr, cpu_regs_pkg::OFS_TMP)) begin
			tmp_q <= merge16(tmp_q, pwdata, pstrb);
		end
	end

	// index register, extra pointer and stack pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ix_q <= cpu_regs_pkg::REG_RST;
			ep_q <= cpu_regs_pkg::REG_RST;
			sp_q <= cpu_regs_pkg::REG_RST;
		end else if (dp_write.valid) begin
			if (dp_write.sel == cpu_regs_pkg::SEL_IX) begin
				ix_q <= dp_write.data;
			end
			if (dp_write.sel == cpu_regs_pkg::SEL_EP) begin
				ep_q <= dp_write.data;
			end
			if (dp_write.sel == cpu_regs_pkg::SEL_SP) begin
				sp_q <= dp_write.data;
			end
		end else if (apb_wr) begin
			if (hit(paddr, cpu_regs_pkg::OFS_IX)) begin
				ix_q <= merge16(ix_q, pwdata, pstrb);
			end
			if (hit(paddr, cpu_regs_pkg::OFS_EP)) begin
				ep_q <= merge16(ep_q, pwdata, pstrb);
			end
			if (hit(paddr, cpu_regs_pkg::OFS_SP)) begin
				sp_q <= merge16(sp_q, pwdata, pstrb);
			end
		end
	end

	// status word: bank pointer high byte, condition codes low byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rp_q  <= cpu_regs_pkg::RP_RST;
			ccr_q <= cpu_regs_pkg::CCR_RST;
		end else if (alu_req.valid) begin
			ccr_q <= ccr_d;
		end else if (dp_write.valid && dp_write.sel == cpu_regs_pkg::SEL_PSW) begin
			rp_q  <= dp_write.data[15:8];
			ccr_q <= dp_write.data[7:0];
		end else if (apb_wr && hit(paddr, cpu_regs_pkg::OFS_PSW)) begin
			rp_q  <= pstrb[1] ? pwdata[15:8] : rp_q;
			ccr_q <= pstrb[0] ? pwdata[7:0] : ccr_q;
		end
	end

	// interrupt gate: enable flag and level mask, level 3 blocks all
	assign irq_accept = irq_pending && ccr_q[cpu_regs_pkg::CCR_I]
		&& ({ccr_q[cpu_regs_pkg::CCR_IL1], ccr_q[cpu_regs_pkg::CCR_IL0]}
			!= cpu_regs_pkg::IL_BLOCK_ALL)
		&& (irq_level < {ccr_q[cpu_regs_pkg::CCR_IL1], ccr_q[cpu_regs_pkg::CCR_IL0]});

	// region decode of the single 64 Kbyte space
	always_comb begin
		if (mem_addr <= cpu_regs_pkg::IO_LAST) begin
			mem_region = cpu_regs_pkg::REGION_IO;
		end else if (mem_addr < PROG_START) begin
			mem_region = cpu_regs_pkg::REGION_DATA;
		end else begin
			mem_region = cpu_regs_pkg::REGION_PROG;
		end
	end

	// general register address from the bank pointer
	assign bank     = rp_q[4:0];
	assign gpr_addr = cpu_regs_pkg::BANK_BASE + {8'h00, bank, 3'h0} + {13'h0000, gpr_index};
	assign gpr_external = (32'(bank) >= INT_BANKS)
		&& (gpr_addr >= cpu_regs_pkg::EXT_BANK_LO) && (gpr_addr <= cpu_regs_pkg::EXT_BANK_HI);

	// read mux; stat word holds the external bank flag and general register address
	always_comb begin
		rdata_d = 32'h00000000;
		unique case (paddr)
			cpu_regs_pkg::OFS_PC:   rdata_d = {16'h0000, pc_q};
			cpu_regs_pkg::OFS_ACC:  rdata_d = {16'h0000, acc_q};
			cpu_regs_pkg::OFS_TMP:  rdata_d = {16'h0000, tmp_q};
			cpu_regs_pkg::OFS_IX:   rdata_d = {16'h0000, ix_q};
			cpu_regs_pkg::OFS_EP:   rdata_d = {16'h0000, ep_q};
			cpu_regs_pkg::OFS_SP:   rdata_d = {16'h0000, sp_q};
			cpu_regs_pkg::OFS_PSW:  rdata_d = {16'h0000, rp_q, ccr_q};
			cpu_regs_pkg::OFS_STAT: rdata_d = {15'h0000, gpr_external, gpr_addr};
			default:                rdata_d = 32'h00000000;
		endcase
	end

	// read data registered on the setup cycle so it is stable in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rdata_d;
		end
	end

	// register contents for the datapath
	assign regs = '{pc: pc_q, acc: acc_q, tmp: tmp_q, ix: ix_q, ep: ep_q, sp: sp_q,
		psw: {rp_q, ccr_q}};

endmodule : cpu_register_and_flags

//--- cpu_regs_pkg.sv
// package of constants and types for the cpu register and flag block
package cpu_regs_pkg;

	// apb byte offsets of the register words
	localparam logic [7:0] OFS_PC   = 8'h00;
	localparam logic [7:0] OFS_ACC  = 8'h04;
	localparam logic [7:0] OFS_TMP  = 8'h08;
	localparam logic [7:0] OFS_IX   = 8'h0C;
	localparam logic [7:0] OFS_EP   = 8'h10;
	localparam logic [7:0] OFS_SP   = 8'h14;
	localparam logic [7:0] OFS_PSW  = 8'h18;
	localparam logic [7:0] OFS_STAT = 8'h1C;

	// condition code bit positions
	localparam int CCR_H   = 7;
	localparam int CCR_I   = 6;
	localparam int CCR_IL1 = 5;
	localparam int CCR_IL0 = 4;
	localparam int CCR_N   = 3;
	localparam int CCR_Z   = 2;
	localparam int CCR_V   = 1;
	localparam int CCR_C   = 0;

	// reset values
	localparam logic [15:0] PC_RST  = 16'h0000;
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [7:0]  RP_RST  = 8'h00;
	localparam logic [7:0]  CCR_RST = 8'h30; // interrupts off, mask at level 3

	// memory map
	localparam logic [15:0] IO_LAST       = 16'h007F;
	localparam logic [15:0] PROG_FIRST    = 16'h8000;
	localparam logic [15:0] BANK_BASE     = 16'h0100;
	localparam logic [15:0] EXT_BANK_LO   = 16'h0180;
	localparam logic [15:0] EXT_BANK_HI   = 16'h01FF;
	localparam int          BANK_REGS     = 8;
	localparam int          BANKS_MAX     = 32;
	localparam int          BANKS_INT     = 16;
	localparam logic [1:0]  IL_BLOCK_ALL  = 2'h3;

	// register selected by a datapath write
	typedef enum logic [2:0] {
		SEL_PC,
		SEL_ACC,
		SEL_TMP,
		SEL_IX,
		SEL_EP,
		SEL_SP,
		SEL_PSW
	} reg_sel_t;

	// arithmetic commands on accumulator and temporary accumulator
	typedef enum logic [2:0] {
		OP_ADD8,
		OP_SUB8,
		OP_ADD16,
		OP_SUB16,
		OP_SHL8,
		OP_SHR8
	} alu_op_t;

	// memory region of an address
	typedef enum logic [1:0] {
		REGION_IO,
		REGION_DATA,
		REGION_PROG
	} region_t;

	// datapath write request
	typedef struct packed {
		logic        valid;
		reg_sel_t    sel;
		logic [15:0] data;
	} dp_write_t;

	// datapath arithmetic request
	typedef struct packed {
		logic    valid;
		alu_op_t op;
	} alu_req_t;

	// contents of the dedicated registers
	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] acc;
		logic [15:0] tmp;
		logic [15:0] ix;
		logic [15:0] ep;
		logic [15:0] sp;
		logic [15:0] psw;
	} cpu_regs_t;

endpackage : cpu_regs_pkg

//--- cpu_regs_assertions.sv
// checker of the cpu register and flag block ports
`timescale 1ns/1ps
module cpu_regs_assertions #(
	parameter logic [15:0] PROG_START = 16'h8000,
	parameter int          INT_BANKS  = 16
) (
	// clock and reset
	input wire logic                    pclk,
	input wire logic                    presetn,
	// datapath, interrupt check and decode
	input wire cpu_regs_pkg::alu_req_t  alu_req,
	input wire logic                    irq_pending,
	input wire logic [1:0]              irq_level,
	input wire logic                    irq_accept,
	input wire logic [15:0]             mem_addr,
	input wire cpu_regs_pkg::region_t   mem_region,
	input wire logic [2:0]              gpr_index,
	input wire logic [15:0]             gpr_addr,
	input wire logic                    gpr_external,
	input wire cpu_regs_pkg::cpu_regs_t regs
);
	logic byte_add;
	logic byte_op;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// byte wide add and subtract seen this cycle
	assign byte_add = alu_req.valid && alu_req.op == cpu_regs_pkg::OP_ADD8;
	assign byte_op = byte_add || (alu_req.valid && alu_req.op == cpu_regs_pkg::OP_SUB8);
	AST_IE_OFF: assert property (!regs.psw[6] |-> !irq_accept)
		else $error("interrupt accepted while disabled");
	AST_IRQ: assert property (irq_accept == (irq_pending && regs.psw[6]
		&& regs.psw[5:4] != 2'h3 && irq_level < regs.psw[5:4]))
		else $error("interrupt accept wrong for level");
	AST_IL3: assert property (regs.psw[5:4] == 2'h3 |-> !irq_accept)
		else $error("mask level 3 did not block");
	AST_ADD8: assert property (byte_add |=> {regs.psw[0], regs.acc[7:0]} ==
		{1'b0, $past(regs.acc[7:0])} + $past(regs.tmp[7:0]))
		else $error("byte add sum or carry wrong");
	AST_HALF: assert property (byte_add |=> regs.psw[7] ==
		(({1'b0, $past(regs.acc[3:0])} + $past(regs.tmp[3:0])) > 5'h0F))
		else $error("half carry wrong");
	AST_HIGH: assert property (byte_op |=> $stable(regs.acc[15:8]))
		else $error("byte operation touched high byte");
	AST_ZERO: assert property (byte_op |=> regs.psw[2] == (regs.acc[7:0] == 8'h00))
		else $error("zero flag wrong");
	AST_NEG: assert property (byte_op |=> regs.psw[3] == regs.acc[7])
		else $error("negative flag wrong");
	AST_BANK: assert property (gpr_addr == cpu_regs_pkg::BANK_BASE
		+ {8'h00, regs.psw[12:8], 3'h0} + {13'h0000, gpr_index})
		else $error("register bank address wrong");
	AST_EXT: assert property (gpr_external == (regs.psw[12:8] >= INT_BANKS))
		else $error("external bank flag wrong");
	AST_IO: assert property (mem_addr <= cpu_regs_pkg::IO_LAST
		|-> mem_region == cpu_regs_pkg::REGION_IO)
		else $error("io region wrong");
	AST_PROG: assert property (mem_addr >= PROG_START
		|-> mem_region == cpu_regs_pkg::REGION_PROG)
		else $error("program region wrong");
endmodule : cpu_regs_assertions

bind cpu_register_and_flags cpu_regs_assertions #(
	.PROG_START(PROG_START),
	.INT_BANKS(INT_BANKS)
) chk_i (.pclk, .presetn, .alu_req, .irq_pending, .irq_level, .irq_accept,
	.mem_addr, .mem_region, .gpr_index, .gpr_addr, .gpr_external, .regs);

//--- datapath_model.sv
// behavioural execution datapath driving loads and arithmetic
`timescale 1ns/1ps
module datapath_model (
	// clock
	input  wire logic               pclk,
	// requests to the register block
	output cpu_regs_pkg::dp_write_t dp_write,
	output cpu_regs_pkg::alu_req_t  alu_req,
	output logic                    pc_step
);
	// idle from time zero
	initial begin
		dp_write = '0;
		alu_req = '0;
		pc_step = 1'b0;
	end
	// one cycle register load; data is scrambled once released
	task automatic load(input cpu_regs_pkg::reg_sel_t s, input logic [15:0] d);
		dp_write <= '{1'b1, s, d};
		@(posedge pclk);
		dp_write <= '{1'b0, s, ~d};
		@(posedge pclk);
	endtask : load
	// one cycle arithmetic of accumulator with temporary accumulator
	task automatic alu(input cpu_regs_pkg::alu_op_t op);
		alu_req <= '{1'b1, op};
		@(posedge pclk);
		alu_req.valid <= 1'b0;
		@(posedge pclk);
	endtask : alu
	// one program counter step
	task automatic step();
		pc_step <= 1'b1;
		@(posedge pclk);
		pc_step <= 1'b0;
		@(posedge pclk);
	endtask : step
endmodule : datapath_model

//--- tb.sv
// self-checking bench of the cpu register and flag block
`timescale 1ns/1ps
module tb;
	typedef struct packed {
		cpu_regs_pkg::alu_op_t op;
		logic [15:0] a;
		logic [15:0] t;
		logic [15:0] r;
		logic [15:0] f;
	} row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic irq_pending, irq_accept, gpr_external, pc_step;
	logic [7:0]  paddr;
	logic [3:0]  pstrb;
	logic [1:0]  irq_level;
	logic [2:0]  gpr_index;
	logic [15:0] mem_addr, gpr_addr;
	logic [31:0] pwdata, prdata, rd;
	cpu_regs_pkg::dp_write_t dp_write;
	cpu_regs_pkg::alu_req_t  alu_req;
	cpu_regs_pkg::region_t   mem_region;
	cpu_regs_pkg::cpu_regs_t regs;
	int n_fail, comparisons;
	logic [7:0]  ofs [3] = '{cpu_regs_pkg::OFS_IX, cpu_regs_pkg::OFS_EP, cpu_regs_pkg::OFS_SP};
	logic [15:0] ma [3] = '{16'h007F, 16'h0080, 16'h8000};
	// operation, acc, tmp, acc after, status word after
	row_t rows [8] = '{
		'{cpu_regs_pkg::OP_ADD8, 16'h12FF, 16'h0001, 16'h1200, 16'h00B5},
		'{cpu_regs_pkg::OP_ADD8, 16'h007F, 16'h0001, 16'h0080, 16'h00BA},
		'{cpu_regs_pkg::OP_SUB8, 16'h0010, 16'h0001, 16'h000F, 16'h00B0},
		'{cpu_regs_pkg::OP_SUB8, 16'h0000, 16'h0001, 16'h00FF, 16'h00B9},
		'{cpu_regs_pkg::OP_SHL8, 16'hA581, 16'h0000, 16'hA502, 16'h00B1},
		'{cpu_regs_pkg::OP_SHR8, 16'h0001, 16'h0000, 16'h0000, 16'h00B5},
		'{cpu_regs_pkg::OP_ADD16, 16'h8000, 16'h8000, 16'h0000, 16'h0037},
		'{cpu_regs_pkg::OP_SUB16, 16'h0000, 16'h0001, 16'hFFFF, 16'h00B9}};
	cpu_register_and_flags cpu_register_and_flags_i (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .dp_write, .alu_req,
		.pc_step, .irq_pending, .irq_level, .irq_accept, .mem_addr, .mem_region,
		.gpr_index, .gpr_addr, .gpr_external, .regs);
	datapath_model datapath_model_i (.pclk, .dp_write, .alu_req, .pc_step);
	// 250 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// compare one value
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer, waiting for pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// write the status word, then judge acceptance of a request level
	task automatic irq_case(input logic [15:0] p, input logic [1:0] lv, input logic ex);
		apb(1'b1, cpu_regs_pkg::OFS_PSW, {16'h0000, p});
		irq_level <= lv;
		@(posedge pclk);
		chk({15'h0000, irq_accept}, {15'h0000, ex});
	endtask : irq_case
	// verdict
	task automatic end_of_test();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	// watchdog
	initial begin
		#100000;
		n_fail++;
		$display("ERROR %0t: timeout", $time);
		end_of_test();
	end
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, irq_pending, irq_level} = '0;
		{mem_addr, gpr_index} = '0;
		pstrb = 4'hF;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, cpu_regs_pkg::OFS_PSW, 32'h0);
		chk(rd[15:0], 16'h0030);
		$display("test reset done");
		foreach (rows[i]) begin
			datapath_model_i.load(cpu_regs_pkg::SEL_ACC, rows[i].a);
			datapath_model_i.load(cpu_regs_pkg::SEL_TMP, rows[i].t);
			datapath_model_i.alu(rows[i].op);
			chk(regs.acc, rows[i].r);
			chk(regs.psw, rows[i].f);
		end
		$display("test arithmetic done");
		foreach (ofs[i]) begin
			apb(1'b1, ofs[i], {16'hFFFF, 16'h5A00 + 16'(i)});
			apb(1'b0, ofs[i], 32'h0);
			chk(rd[15:0], 16'h5A00 + 16'(i));
			chk(rd[31:16], 16'h0000);
		end
		// datapath loads of the pointer registers
		datapath_model_i.load(cpu_regs_pkg::SEL_IX, 16'h1357);
		chk(regs.ix, 16'h1357);
		datapath_model_i.load(cpu_regs_pkg::SEL_EP, 16'h2468);
		chk(regs.ep, 16'h2468);
		datapath_model_i.load(cpu_regs_pkg::SEL_SP, 16'h369C);
		chk(regs.sp, 16'h369C);
		// low lane only: high byte of the temporary accumulator kept
		pstrb <= 4'h1;
		apb(1'b1, cpu_regs_pkg::OFS_TMP, 32'h0000ABCD);
		pstrb <= 4'hF;
		chk(regs.tmp, 16'h00CD);
		datapath_model_i.step();
		apb(1'b0, cpu_regs_pkg::OFS_PC, 32'h0);
		chk(rd[15:0], 16'h0001);
		apb(1'b0, 8'h20, 32'h0);
		chk({15'h0000, er}, 16'h0001);
		$display("test apb done");
		irq_pending <= 1'b1;
		gpr_index <= 3'h5;
		irq_case(16'h1160, 2'h1, 1'b1);
		chk(gpr_addr, 16'h018D);
		apb(1'b0, cpu_regs_pkg::OFS_STAT, 32'h0);
		chk({15'h0000, rd[16]}, 16'h0001);
		apb(1'b1, cpu_regs_pkg::OFS_STAT, 32'h0);
		chk({15'h0000, er}, 16'h0001);
		irq_case(16'h0F60, 2'h0, 1'b1);
		chk(gpr_addr, 16'h017D);
		chk({15'h0000, gpr_external}, 16'h0000);
		irq_case(16'h0060, 2'h2, 1'b0);
		irq_case(16'h0070, 2'h0, 1'b0);
		irq_case(16'h0020, 2'h0, 1'b0);
		$display("test interrupt and bank done");
		foreach (ma[i]) begin
			mem_addr <= ma[i];
			@(posedge pclk);
			chk({14'h0000, mem_region}, 16'(i));
		end
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, cpu_regs_pkg::OFS_PSW, 32'h0);
		chk(rd[15:0], 16'h0030);
		$display("test region and second reset done");
		end_of_test();
	end
endmodule : tb
